// File: inc/rtcis_pkg.sv
/*
  Shared constants and types of the two-wire clock-chip slave link.
  Assumes both ends and the bench compile this package first.
*/
package rtcis_pkg;
  // --------------------------------------------------------------
  // Addressing
  // --------------------------------------------------------------
  localparam logic [6:0] SLV_ADDR  = 7'h68;
  localparam int         PTR_W     = 6;
  localparam logic [5:0] PTR_FIRST = 6'h00;
  localparam logic [5:0] PTR_LAST  = 6'h3f;
  localparam logic [3:0] BITC_BYTE = 4'h8;
  localparam logic [3:0] BITC_ACK  = 4'h9;
  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int TIMEOUT_MS     = 35;
  localparam int LINK_PERIOD_NS = 30;
  localparam int TIMEOUT_CYC    = TIMEOUT_MS * 1000000 / LINK_PERIOD_NS;
  localparam int SYS_FREQ_KHZ   = 100000;
  localparam int SCL_STD_KHZ    = 100;
  localparam int SCL_FAST_KHZ   = 400;
  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_ADDR  = 3'b001,
    D_PTR   = 3'b010,
    D_WDATA = 3'b011,
    D_RDATA = 3'b100
  } rtcis_dst_t;
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_STOP  = 2'b11
  } rtcis_op_t;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b10,
    H_STOP  = 2'b11
  } rtcis_hst_t;
endpackage : rtcis_pkg

// File: inc/rtcis_if.sv
/*
  Open-drain two-wire bus between the bus master and the clock slave.
  Assumes a pull-up: a line is low only while some party drives it.
*/
`timescale 1ns/1ns
interface rtcis_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport dev  (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
endinterface : rtcis_if

// File: rtl/rtcis_dev.sv
/*
  Slave end of the two-wire link of a real-time clock: condition
  detection, address decode, register pointer, acknowledge, read
  shifting and clock-low timeout. Link logic runs on clk_link and
  oversamples both lines; the register side runs on clk_sys.
  Assumes the register file answers rd_data in the rd_stb cycle.
//
// Contract
// - Slave only; master clocks, up to 400kHz
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - SDA changes only while SCL low
// - Master starts only on idle bus
// - Bytes MSB first, ninth pulse acknowledges
// - Acknowledger holds SDA low whole pulse
// - Acknowledge every byte once addressed
// - Master NACKs last read byte; release
// - Long SCL low resets, await START
// - Address 1101000, direction 0 writes
// - Direction 1 selects a read
// - Acknowledge a matching address byte
// - First write byte loads pointer
// - Store data bytes, increment pointer
// - Read starts at current pointer
// - Read increments pointer until NACK
// - End by STOP or repeated START
// - Unlimited bytes per transfer
// - Pointer wraps from last to zero
// - Snapshot on START, STOP, wrap
// - Commit written byte at its acknowledge
*/
`timescale 1ns/1ns
module rtcis_dev #(
  parameter int TIMEOUT_CYC = rtcis_pkg::TIMEOUT_CYC
) (
  // Clocks and reset
  input  wire logic                     clk_link,
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // Bus pins
  rtcis_if.dev                          bus,
  // Register side, clk_sys
  output logic [rtcis_pkg::PTR_W-1:0]   reg_addr,
  output logic [7:0]                    wr_data,
  output logic                          wr_stb,
  output logic                          rd_stb,
  input  wire logic [7:0]               rd_data,
  output logic                          snap_stb
);
  import rtcis_pkg::*;

  localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_LIM = TMO_W'(TIMEOUT_CYC);

  if (TIMEOUT_CYC < 2) begin : g_chk
    $error("rtcis_dev: TIMEOUT_CYC must be at least 2");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       scl_sy;
    logic [1:0]       sda_sy;
    logic             scl_d;
    logic             sda_d;
    rtcis_dst_t       st;
    logic [3:0]       bitc;
    logic [7:0]       sh;
    logic [7:0]       tx;
    logic             rw;
    logic             nack;
    logic [PTR_W-1:0] ptr;
    logic             drv;
    logic [TMO_W-1:0] tmo;
    logic             wr_t;
    logic             rd_t;
    logic             snap_t;
    logic [PTR_W-1:0] ev_addr;
    logic [7:0]       ev_data;
    logic [1:0]       rda_sy;
    logic             rda_d;
  } rtcis_lnk_t;

  typedef struct packed {
    logic [1:0]       wr_sy;
    logic             wr_d;
    logic [1:0]       rd_sy;
    logic             rd_d;
    logic [1:0]       snap_sy;
    logic             snap_d;
    logic             pend;
    logic             rda_t;
    logic [7:0]       rd_buf;
    logic [PTR_W-1:0] reg_addr;
    logic [7:0]       wr_data;
    logic             wr_stb;
    logic             rd_stb;
    logic             snap_stb;
  } rtcis_sys_t;

  rtcis_lnk_t l_r, l_nxt;
  rtcis_sys_t s_r, s_nxt;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_LAST) ? PTR_FIRST : PTR_W'(p + 1'b1);
  endfunction : ptr_inc

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  // The device never drives the clock, so SCL is only observed.
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [PTR_W-1:0] nptr;

  always_comb begin
    l_nxt = l_r;
    l_nxt.scl_sy = {l_r.scl_sy[0], bus.scl};
    l_nxt.sda_sy = {l_r.sda_sy[0], bus.sda};
    l_nxt.scl_d  = l_r.scl_sy[1];
    l_nxt.sda_d  = l_r.sda_sy[1];
    scl   = l_r.scl_sy[1];
    sda   = l_r.sda_sy[1];
    rise  = scl & ~l_r.scl_d;
    fall  = ~scl & l_r.scl_d;
    start = scl & l_r.scl_d & l_r.sda_d & ~sda;
    stop  = scl & l_r.scl_d & ~l_r.sda_d & sda;
    nptr  = ptr_inc(l_r.ptr);
    // The fetched byte is held still by the register side until the
    // next fetch, so it is taken once the returned toggle is synced.
    l_nxt.rda_sy = {l_r.rda_sy[0], s_r.rda_t};
    l_nxt.rda_d  = l_r.rda_sy[1];
    if (l_r.rda_sy[1] != l_r.rda_d) begin
      l_nxt.tx = s_r.rd_buf;
    end
    if (scl) begin
      l_nxt.tmo = '0;
    end else if (l_r.tmo != TMO_LIM) begin
      l_nxt.tmo = TMO_W'(l_r.tmo + 1'b1);
    end
    if (start) begin
      l_nxt.st     = D_ADDR;
      l_nxt.bitc   = '0;
      l_nxt.drv    = 1'b0;
      l_nxt.snap_t = ~l_r.snap_t;
    end else if (stop) begin
      l_nxt.st     = D_IDLE;
      l_nxt.drv    = 1'b0;
      l_nxt.snap_t = ~l_r.snap_t;
    end else if (l_r.tmo == TMO_LIM) begin
      l_nxt.st  = D_IDLE;
      l_nxt.drv = 1'b0;
    end else if (l_r.st != D_IDLE) begin
      if (rise) begin
        if (l_r.bitc < BITC_BYTE) begin
          l_nxt.sh   = {l_r.sh[6:0], sda};
          l_nxt.bitc = 4'(l_r.bitc + 1'b1);
        end else if (l_r.bitc == BITC_ACK) begin
          l_nxt.nack = sda;
        end
      end else if (fall) begin
        if (l_r.bitc == BITC_BYTE) begin
          l_nxt.bitc = BITC_ACK;
          unique case (l_r.st)
            D_ADDR: begin
              if (l_r.sh[7:1] == SLV_ADDR) begin
                l_nxt.drv = 1'b1;
                l_nxt.rw  = l_r.sh[0];
                if (l_r.sh[0]) begin
                  l_nxt.ev_addr = l_r.ptr;
                  l_nxt.rd_t    = ~l_r.rd_t;
                end
              end else begin
                l_nxt.st = D_IDLE;
              end
            end
            D_PTR: begin
              l_nxt.drv = 1'b1;
              l_nxt.ptr = l_r.sh[PTR_W-1:0];
            end
            D_WDATA: begin
              l_nxt.drv     = 1'b1;
              l_nxt.ev_addr = l_r.ptr;
              l_nxt.ev_data = l_r.sh;
              l_nxt.wr_t    = ~l_r.wr_t;
            end
            D_RDATA: begin
              l_nxt.drv     = 1'b0;
              l_nxt.ptr     = nptr;
              l_nxt.ev_addr = nptr;
              l_nxt.rd_t    = ~l_r.rd_t;
              if (nptr == PTR_FIRST) begin
                l_nxt.snap_t = ~l_r.snap_t;
              end
            end
            default: l_nxt.st = D_IDLE;
          endcase
        end else if (l_r.bitc == BITC_ACK) begin
          // Ack slot over: the held low is released only now, so it
          // spans the whole high phase of the ninth pulse.
          l_nxt.bitc = '0;
          l_nxt.drv  = 1'b0;
          unique case (l_r.st)
            D_ADDR: begin
              l_nxt.st  = l_r.rw ? D_RDATA : D_PTR;
              l_nxt.drv = l_r.rw & ~l_r.tx[7];
            end
            D_PTR:   l_nxt.st = D_WDATA;
            D_WDATA: begin
              l_nxt.ptr = nptr;
              if (nptr == PTR_FIRST) begin
                l_nxt.snap_t = ~l_r.snap_t;
              end
            end
            D_RDATA: begin
              if (l_r.nack) begin
                l_nxt.st = D_IDLE;
              end else begin
                l_nxt.drv = ~l_r.tx[7];
              end
            end
            default: l_nxt.st = D_IDLE;
          endcase
        end else if (l_r.st == D_RDATA) begin
          l_nxt.drv = ~l_r.tx[~l_r.bitc[2:0]];
        end
      end
    end
  end

  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      l_r    <= '0;
      l_r.st <= D_IDLE;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = l_r.drv;

  // ----------------------------------------------------------------
  // Register side
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_sy    = {s_r.wr_sy[0], l_r.wr_t};
    s_nxt.rd_sy    = {s_r.rd_sy[0], l_r.rd_t};
    s_nxt.snap_sy  = {s_r.snap_sy[0], l_r.snap_t};
    s_nxt.wr_d     = s_r.wr_sy[1];
    s_nxt.rd_d     = s_r.rd_sy[1];
    s_nxt.snap_d   = s_r.snap_sy[1];
    s_nxt.wr_stb   = s_r.wr_sy[1] ^ s_r.wr_d;
    s_nxt.rd_stb   = s_r.rd_sy[1] ^ s_r.rd_d;
    s_nxt.snap_stb = s_r.snap_sy[1] ^ s_r.snap_d;
    s_nxt.pend     = 1'b0;
    if (s_nxt.wr_stb) begin
      s_nxt.reg_addr = l_r.ev_addr;
      s_nxt.wr_data  = l_r.ev_data;
    end
    if (s_nxt.rd_stb) begin
      s_nxt.reg_addr = l_r.ev_addr;
      s_nxt.pend     = 1'b1;
    end
    if (s_r.pend) begin
      s_nxt.rd_buf = rd_data;
      s_nxt.rda_t  = ~s_r.rda_t;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_addr = s_r.reg_addr;
  assign wr_data  = s_r.wr_data;
  assign wr_stb   = s_r.wr_stb;
  assign rd_stb   = s_r.rd_stb;
  assign snap_stb = s_r.snap_stb;
endmodule : rtcis_dev

// File: rtl/rtcis_host.sv
/*
  Master end of the two-wire clock-chip link: makes SCL from clk_sys
  by a quarter-period divider and runs byte-level commands.
  Assumes it is the only master on the bus and no clock stretching.
*/
`timescale 1ns/1ns
module rtcis_host #(
  parameter int SCL_KHZ = rtcis_pkg::SCL_FAST_KHZ
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // Bus pins
  rtcis_if.host                     bus,
  // Command
  input  wire logic                 cmd_valid,
  input  wire rtcis_pkg::rtcis_op_t cmd_op,
  input  wire logic [7:0]           cmd_data,
  input  wire logic                 cmd_ack,
  output logic                      cmd_ready,
  // Response
  output logic                      rsp_valid,
  output logic [7:0]                rsp_data,
  output logic                      rsp_nack
);
  import rtcis_pkg::*;

  localparam int QTR = (SYS_FREQ_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  localparam int CW  = $clog2(QTR);
  localparam logic [CW-1:0] QTR_LAST = CW'(QTR - 1);

  if (SCL_KHZ > SCL_FAST_KHZ || SCL_KHZ < 1 || QTR < 2) begin : g_chk
    $error("rtcis_host: SCL_KHZ out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rtcis_hst_t st;
    logic [CW-1:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitc;
    logic [8:0] sh;
    logic [8:0] rx;
    logic [1:0] sda_sy;
    logic scl_lo;
    logic sda_lo;
    logic ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
  } rtcis_hreg_t;

  rtcis_hreg_t r_r, r_nxt;
  logic tick;

  always_comb begin
    r_nxt = r_r;
    r_nxt.sda_sy    = {r_r.sda_sy[0], bus.sda};
    r_nxt.rsp_valid = 1'b0;
    tick = (r_r.cnt == QTR_LAST);
    r_nxt.cnt = tick ? '0 : CW'(r_r.cnt + 1'b1);
    if (tick) begin
      r_nxt.ph = 2'(r_r.ph + 1'b1);
    end
    unique case (r_r.st)
      H_IDLE: begin
        r_nxt.cnt = '0;
        r_nxt.ph  = '0;
        if (cmd_valid && r_r.ready) begin
          unique case (cmd_op)
            OP_START: begin
              // A fresh START only on a free bus; a repeated one while
              // the clock is already held low by this end.
              if (r_r.scl_lo || r_r.sda_sy[1]) begin
                r_nxt.st     = H_START;
                r_nxt.scl_lo = 1'b1;
                r_nxt.sda_lo = 1'b0;
              end
            end
            OP_WRITE: begin
              r_nxt.st     = H_BIT;
              r_nxt.bitc   = '0;
              r_nxt.sh     = {cmd_data, 1'b1};
              r_nxt.sda_lo = ~cmd_data[7];
            end
            OP_READ: begin
              r_nxt.st     = H_BIT;
              r_nxt.bitc   = '0;
              r_nxt.sh     = {8'hff, ~cmd_ack};
              r_nxt.sda_lo = 1'b0;
            end
            OP_STOP: begin
              r_nxt.st     = H_STOP;
              r_nxt.sda_lo = 1'b1;
            end
            default: r_nxt.st = H_IDLE;
          endcase
        end
      end
      H_START: begin
        if (tick) begin
          unique case (r_r.ph)
            2'h0: r_nxt.scl_lo = 1'b0;
            2'h1: r_nxt.sda_lo = 1'b1;
            2'h2: r_nxt.scl_lo = 1'b1;
            2'h3: r_nxt.st     = H_IDLE;
            default: r_nxt.st  = H_IDLE;
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          unique case (r_r.ph)
            2'h0: r_nxt.scl_lo = 1'b0;
            2'h1: r_nxt.rx     = {r_r.rx[7:0], r_r.sda_sy[1]};
            2'h2: r_nxt.scl_lo = 1'b1;
            2'h3: begin
              // Data moves a full quarter after the falling clock.
              r_nxt.sh     = {r_r.sh[7:0], 1'b1};
              r_nxt.sda_lo = ~r_r.sh[7];
              r_nxt.bitc   = 4'(r_r.bitc + 1'b1);
              if (r_r.bitc == BITC_BYTE) begin
                r_nxt.st        = H_IDLE;
                r_nxt.sda_lo    = 1'b0;
                r_nxt.rsp_valid = 1'b1;
                r_nxt.rsp_data  = r_r.rx[8:1];
                r_nxt.rsp_nack  = r_r.rx[0];
              end
            end
            default: r_nxt.st = H_IDLE;
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          unique case (r_r.ph)
            2'h0: r_nxt.scl_lo = 1'b0;
            2'h1: r_nxt.sda_lo = 1'b0;
            2'h2: r_nxt.st     = H_STOP;
            2'h3: r_nxt.st     = H_IDLE;
            default: r_nxt.st  = H_IDLE;
          endcase
        end
      end
      default: r_nxt.st = H_IDLE;
    endcase
    r_nxt.ready = (r_nxt.st == H_IDLE) && !r_nxt.rsp_valid;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_r        <= '0;
      r_r.st     <= H_IDLE;
      r_r.sda_sy <= 2'h3;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = r_r.scl_lo;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = r_r.sda_lo;
  assign cmd_ready    = r_r.ready;
  assign rsp_valid    = r_r.rsp_valid;
  assign rsp_data     = r_r.rsp_data;
  assign rsp_nack     = r_r.rsp_nack;
endmodule : rtcis_host

// File: verif/rtcis_assertions.sv
/*
  Bus-level checker of the clock-chip slave link: follows the wired
  lines on clk_sys and checks how the slave end uses SDA.
  Assumes the top bench instantiates it beside the bus interface.
*/
`timescale 1ns/1ns
module rtcis_assertions #(
  parameter int TMO_SYS = 6000
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Wired lines and slave enable
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic s_sda_oe
);
  import rtcis_pkg::*;
  // ------------------------------------------------------------
  // Bus follower
  // ------------------------------------------------------------
  logic       scl_q, sda_q, first_r, wmode_r, rmode_r, frgn_r, rdone_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  int         low_r;
  wire start_w = scl && scl_q && sda_q && !sda;
  wire stop_w  = scl && scl_q && !sda_q && sda;
  wire rise_w  = scl && !scl_q;
  wire ack9_w  = rise_w && cnt_r == BITC_BYTE;
  wire match_w = sh_r[7:1] == SLV_ADDR;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {scl_q, sda_q} <= 2'h3;
      {first_r, wmode_r, rmode_r, frgn_r, rdone_r} <= 5'h00;
      cnt_r <= 4'h0;
      sh_r  <= 8'h00;
      low_r <= 0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      low_r <= scl ? 0 : low_r + 1;
      if (rise_w) begin
        sh_r  <= {sh_r[6:0], sda};
        cnt_r <= (cnt_r == BITC_ACK) ? 4'h1 : cnt_r + 4'h1;
      end
      if (ack9_w) begin
        first_r <= 1'b0;
        if (first_r) begin
          wmode_r <= match_w && !sh_r[0];
          rmode_r <= match_w && sh_r[0];
          frgn_r  <= !match_w;
        end
        if (rmode_r && sda) begin
          rdone_r <= 1'b1;
        end
      end
      // The slave forgets the transfer on these, so the follower does too.
      // Its timeout is taken late, after the slave's synced timeout.
      if (start_w || stop_w || low_r == TMO_SYS + 30) begin
        cnt_r <= 4'h0;
        first_r <= start_w;
        {wmode_r, rmode_r, frgn_r, rdone_r} <= 4'h0;
      end
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_quiet;
    (!s_sda_oe) [*8];
  endsequence
  sequence s_ack_low;
    s_sda_oe && !sda;
  endsequence

  a_addr_ack: assert property (ack9_w && first_r && match_w |-> s_ack_low)
    else $error("slave did not acknowledge its address");
  a_foreign_nack: assert property (ack9_w && first_r && !match_w |-> sda)
    else $error("foreign address acknowledged");
  a_ignore_foreign: assert property (frgn_r |-> !s_sda_oe)
    else $error("slave drove after foreign address");
  a_data_ack: assert property (ack9_w && !first_r && wmode_r |-> s_ack_low)
    else $error("written byte not acknowledged");
  a_read_turn: assert property (ack9_w && !first_r && rmode_r |-> !s_sda_oe)
    else $error("slave held SDA in master ack slot");
  a_read_done: assert property (rdone_r |-> !s_sda_oe)
    else $error("slave drove after not-acknowledge");
  a_sda_steady: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave changed SDA while SCL high");
  a_ack_held: assert property (s_sda_oe && scl |=> s_sda_oe || !scl)
    else $error("slave released SDA inside high phase");
  a_ack_slot: assert property (s_sda_oe && !rmode_r |-> cnt_r >= BITC_BYTE)
    else $error("slave drove SDA outside ninth bit");
  a_start_quiet: assert property (start_w |-> s_quiet)
    else $error("slave drove SDA right after start");
  a_stop_quiet: assert property (stop_w |-> s_quiet)
    else $error("slave drove SDA right after stop");
  a_tmo_release: assert property (low_r == TMO_SYS + 30 |-> !s_sda_oe)
    else $error("slave kept SDA after clock-low timeout");
endmodule : rtcis_assertions

// File: verif/rtcis_tb_top.sv
/*
  Top bench: master end and slave end joined by the bus interface,
  a register file model on the slave's register side, byte tests.
  Assumes the package, interface and both ends are compiled first.
*/
`timescale 1ns/1ns
module rtcis_tb_top;
  import rtcis_pkg::*;
  localparam int TMO = 2000;
  logic            clk_sys, clk_link, resetn;
  logic            cmd_valid, cmd_ack, cmd_ready, rsp_valid, rsp_nack;
  rtcis_op_t       cmd_op;
  logic [7:0]      cmd_data, rsp_data, wr_data, rd_data;
  logic [5:0]      reg_addr;
  logic            wr_stb, rd_stb, snap_stb;
  logic [7:0]      regs [64];
  logic [5:0]      wexp [3] = '{6'h3e, 6'h3f, 6'h00};
  int              error_cnt, check_count, wr_n, snap_n;

  rtcis_if bus_i ();
  rtcis_host u_rtcis_host (.clk_sys(clk_sys), .resetn(resetn),
    .bus(bus_i.host), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  rtcis_dev #(.TIMEOUT_CYC(TMO)) u_rtcis_dev (.clk_link(clk_link),
    .clk_sys(clk_sys), .resetn(resetn), .bus(bus_i.dev),
    .reg_addr(reg_addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .snap_stb(snap_stb));
  rtcis_assertions #(.TMO_SYS(TMO * 3)) u_rtcis_assertions (
    .clk_sys(clk_sys), .resetn(resetn), .scl(bus_i.scl),
    .sda(bus_i.sda), .s_sda_oe(bus_i.s_sda_oe));

  // The register file answers in the strobe cycle, as the slave expects.
  assign rd_data = regs[reg_addr];

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #15 clk_link = ~clk_link;
  end
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  always @(negedge clk_sys) begin
    if (snap_stb === 1'b1) snap_n++;
    if (wr_stb === 1'b1) begin
      chk("write address", {2'h0, reg_addr}, {2'h0, wexp[wr_n]});
      chk("commit in ack", {7'h0, bus_i.s_sda_oe}, 8'h01);
      regs[reg_addr] = wr_data;
      wr_n++;
    end
  end
  // ------------------------------------------------------------
  // Master command tasks
  // ------------------------------------------------------------
  task automatic do_cmd(input rtcis_op_t op, input logic [7:0] d,
                        input logic a);
    int   n;
    logic byt;
    n = 0;
    byt = (op == OP_WRITE) || (op == OP_READ);
    while (cmd_ready !== 1'b1 && n < 6000) begin
      @(negedge clk_sys);
      n++;
    end
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    @(negedge clk_sys);
    n = 0;
    while ((byt ? rsp_valid : cmd_ready) !== 1'b1 && n < 6000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 6000) chk("command done", 8'h00, 8'h01);
  endtask : do_cmd

  task automatic wr(input logic [7:0] d, input logic nack);
    do_cmd(OP_WRITE, d, 1'b1);
    chk("ack bit", {7'h0, rsp_nack}, {7'h0, nack});
    chk("write echo", rsp_data, d);
  endtask : wr

  task automatic rd(input logic a, input logic [7:0] exp);
    do_cmd(OP_READ, 8'h00, a);
    chk("read byte", rsp_data, exp);
  endtask : rd
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b1;
    {error_cnt, check_count, wr_n, snap_n} = '0;
    for (int i = 0; i < 64; i++) regs[i] = 8'(i) ^ 8'h96;
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    // Write across the top of the map.
    do_cmd(OP_START, 8'h00, 1'b1);
    wr(8'hd0, 1'b0);
    wr(8'h3e, 1'b0);
    wr(8'ha5, 1'b0);
    wr(8'h5a, 1'b0);
    wr(8'hc3, 1'b0);
    do_cmd(OP_STOP, 8'h00, 1'b1);
    chk("snapshots", 8'(snap_n), 8'h03);
    // Pointer write, repeated start, read back.
    do_cmd(OP_START, 8'h00, 1'b1);
    wr(8'hd0, 1'b0);
    wr(8'h3e, 1'b0);
    do_cmd(OP_START, 8'h00, 1'b1);
    wr(8'hd1, 1'b0);
    rd(1'b1, 8'ha5);
    rd(1'b1, 8'h5a);
    rd(1'b0, 8'hc3);
    do_cmd(OP_STOP, 8'h00, 1'b1);
    // Read from the pointer left by the prefetch, one past 00.
    do_cmd(OP_START, 8'h00, 1'b1);
    wr(8'hd1, 1'b0);
    rd(1'b0, 8'h97);
    do_cmd(OP_STOP, 8'h00, 1'b1);
    // Foreign address, then a byte that must be ignored.
    do_cmd(OP_START, 8'h00, 1'b1);
    wr(8'ha0, 1'b1);
    wr(8'h11, 1'b1);
    do_cmd(OP_STOP, 8'h00, 1'b1);
    // Clock held low past the timeout drops the transfer. The stall
    // falls while the slave pulls SDA for bit 7 of 5a.
    do_cmd(OP_START, 8'h00, 1'b1);
    wr(8'hd0, 1'b0);
    wr(8'h3e, 1'b0);
    do_cmd(OP_START, 8'h00, 1'b1);
    wr(8'hd1, 1'b0);
    rd(1'b1, 8'ha5);
    repeat (TMO * 3 + 300) @(negedge clk_sys);
    rd(1'b0, 8'hff);
    wr(8'h3e, 1'b1);
    do_cmd(OP_STOP, 8'h00, 1'b1);
    chk("write count", 8'(wr_n), 8'h03);
    stop_test();
  end

  initial begin
    #1000000;
    error_cnt++;
    stop_test();
  end
endmodule : rtcis_tb_top
